// ---- rtl/blt_params.svh ----
/*
  Constants for the backplane negotiation and training register bank: register indices,
  field positions, reset values and bus response codes.
  Assumes it is included by bare name into the files that need it.
*/
`ifndef BLT_PARAMS_SVH
`define BLT_PARAMS_SVH

// Register indices; the byte address is four times the index
`define BLT_IDX_OVR_EN 8'hC0
`define BLT_IDX_LINK_RDY 8'hC2
`define BLT_IDX_ABILITY 8'hCB
`define BLT_IDX_MASTER 8'hCC
`define BLT_IDX_COEF_CTL 8'hD0
`define BLT_IDX_STROBES 8'hD1
`define BLT_IDX_COEF_FIRST 8'hD4
`define BLT_IDX_COEF_LAST 8'hD7

// Field positions
`define BLT_OVR_EN_BIT 6
`define BLT_LINK_RDY_LSB 12
`define BLT_PART_OVR_BIT 16
`define BLT_LOCAL_OVR_BIT 17
`define BLT_RESTART_LSB 0
`define BLT_PART_NEW_LSB 4
`define BLT_LOCAL_NEW_LSB 8
`define BLT_PART_COEF_LSB 0
`define BLT_LOCAL_COEF_LSB 16
`define BLT_KR4_ABILITY_BIT 3

// Reset values and codes
`define BLT_LINK_RDY_RST 6'h08
`define BLT_LINK_RDY_KR4 6'h08
`define BLT_LINK_RDY_NONE 6'h00
`define BLT_ABILITY_RST 25'h0000000
`define BLT_MASTER_RST 4'h0
`define BLT_COEF_RST 8'h00

// Bus responses
`define BLT_RESP_OKAY 2'h0
`define BLT_RESP_SLVERR 2'h2

`endif

// ---- rtl/blt_pkg.sv ----
/*
  Types for the backplane negotiation and training register bank.
  Assumes nothing of its surroundings.
*/
package blt_pkg;
  typedef logic [3:0] blt_lane_mask_t;
  typedef logic [7:0] blt_coef_t;
  typedef logic [1:0] blt_resp_t;
  // Result of decoding a register index
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_OVR_EN,
    SEL_LINK_RDY,
    SEL_ABILITY,
    SEL_MASTER,
    SEL_COEF_CTL,
    SEL_STROBES,
    SEL_COEF
  } blt_sel_t;
endpackage : blt_pkg

// ---- rtl/blt_sc_strobe.sv ----
/*
  Self-clearing strobe bits: a write of one raises the bit for exactly one clock.
  Assumes the write enable is a single-cycle pulse per bus write.
*/
`timescale 1ns/10ps
module blt_sc_strobe
  import blt_pkg::*;
#(
  parameter int WIDTH = 12
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] setBits,
  output logic [WIDTH-1:0] pulse
);
  logic [WIDTH-1:0] pulse_q;

  // One pulse per write, cleared on the next edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pulse_q <= '0;
    end
    else
    begin
      pulse_q <= wrEn ? setBits : '0;
    end
  end
  assign pulse = pulse_q;
endmodule : blt_sc_strobe

// ---- rtl/blt_lane_coef.sv ----
/*
  One lane's coefficient override: software values, the values latched on a strobe,
  and the selection between software and training-derived coefficients.
  Assumes strobes are one-cycle pulses and override enables are steady levels.
*/
`timescale 1ns/10ps
`include "blt_params.svh"
module blt_lane_coef
  import blt_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  input wire logic [31:0] wrMask,
  input wire logic partnerOvr,
  input wire logic localOvr,
  input wire logic partnerStrobe,
  input wire logic localStrobe,
  input wire blt_coef_t trainPartnerCoef,
  input wire blt_coef_t derivedLocalCoef,
  output blt_coef_t swPartner,
  output blt_coef_t swLocal,
  output logic partnerLoad,
  output logic localLoad,
  output blt_coef_t partnerCoef,
  output blt_coef_t localCoef
);
  blt_coef_t swPartner_q, swLocal_q, partnerSent_q, localSent_q, partnerCoef_q, localCoef_q;
  logic [31:0] merged;

  assign merged = ({8'h00, swLocal_q, 8'h00, swPartner_q} & ~wrMask) | (wrData & wrMask);
  // Strobes count only while the matching override is set
  // override gates strobes
  assign partnerLoad = partnerStrobe & partnerOvr;
  assign localLoad = localStrobe & localOvr;

  // Software values and values latched on strobes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      swPartner_q <= `BLT_COEF_RST;
      swLocal_q <= `BLT_COEF_RST;
      partnerSent_q <= `BLT_COEF_RST;
      localSent_q <= `BLT_COEF_RST;
    end
    else
    begin
      if (wrEn)
      begin
        swPartner_q <= merged[`BLT_PART_COEF_LSB +: 8];
        swLocal_q <= merged[`BLT_LOCAL_COEF_LSB +: 8];
      end
      if (partnerLoad)
        partnerSent_q <= swPartner_q;
      if (localLoad)
        localSent_q <= swLocal_q;
    end
  end

  // Registered outputs: software path under override, training path otherwise
  // output path select
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      partnerCoef_q <= `BLT_COEF_RST;
      localCoef_q <= `BLT_COEF_RST;
    end
    else
    begin
      partnerCoef_q <= partnerOvr ? (partnerLoad ? swPartner_q : partnerSent_q) : trainPartnerCoef;
      localCoef_q <= localOvr ? (localLoad ? swLocal_q : localSent_q) : derivedLocalCoef;
    end
  end
  assign swPartner = swPartner_q;
  assign swLocal = swLocal_q;
  assign partnerCoef = partnerCoef_q;
  assign localCoef = localCoef_q;

  property p_partner_sw;
    @(posedge clock) disable iff (rst)
    partnerLoad |=> partnerCoef == $past(swPartner_q);
  endproperty
  a_partner_sw: assert property (p_partner_sw) else $error("partner coef not loaded");
  property p_local_rx;
    @(posedge clock) disable iff (rst)
    !localOvr |=> localCoef == $past(derivedLocalCoef);
  endproperty
  a_local_rx: assert property (p_local_rx) else $error("local coef not derived");
endmodule : blt_lane_coef

// ---- rtl/blt_regs.sv ----
/*
  Register bank for backplane auto-negotiation and link training of a four-lane port,
  reached over AXI4-Lite. Holds partner ability, link-ready status, master lane override
  and per-lane training controls with self-clearing strobes.
  Assumes one clock, an AXI4-Lite master that keeps one write and one read in flight,
  and negotiation/training logic outside that consumes the outputs.
*/
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "blt_params.svh"

// Operation
// - Link-ready field is one-hot; only the 40G four-lane backplane code is valid.
// - Link-ready bits 17:12 show receive-idle true with link up.
// - Partner ability field, 25 bits, read-only, resets to zero.
// - Only ability bit 3 counts as a valid partner technology.
// - Master lane select is four-bit one-hot, resets to zero.
// - With override enable set, selected lane is master; else build-time lane.
// - Partner override set: partner update commands come from software values.
// - Local override set: software sets local coefficients; else partner commands.
// - Per-lane coefficient registers: partner in bits 7:0, local in 23:16.
// - Writing one to restart bit restarts that lane's training, then self-clears.
// - Writing one to partner-new bit sends software partner values, then self-clears.
// - Partner-new strobe does nothing unless partner override is set.
// - Local-new strobe applies software local values only under local override.
module blt_regs
  import blt_pkg::*;
#(
  parameter blt_lane_mask_t DEFAULT_MASTER_LANE = 4'h1
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output blt_resp_t bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output blt_resp_t rresp,
  input wire logic anReceiveIdle,
  input wire logic anLinkUp,
  input wire logic abilityValid,
  input wire logic [24:0] partnerAbility,
  output logic partnerKr4Ok,
  output blt_lane_mask_t masterLane,
  output blt_lane_mask_t restartTraining,
  output blt_lane_mask_t partnerCoefLoad,
  output blt_lane_mask_t localCoefLoad,
  input wire logic [31:0] trainPartnerCoef,
  input wire logic [31:0] derivedLocalCoef,
  output logic [31:0] partnerCoef,
  output logic [31:0] localCoef
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic awHeld_q, wHeld_q, bvalid_q, rvalid_q, overrideEn_q, partnerOvr_q, localOvr_q;
  logic [11:0] awAddr_q;
  logic [31:0] wData_q, rdata_q, wrMask;
  logic [3:0] wStrb_q;
  blt_resp_t bresp_q, rresp_q;
  logic [5:0] linkReady_q;
  logic [24:0] ability_q;
  blt_lane_mask_t masterSel_q, masterLane_q;
  logic doWrite, selOneHot;
  blt_sel_t wrSel, rdSel;
  logic [11:0] strobes;
  logic [31:0] swPartnerAll, swLocalAll;

  // Decode a byte address into a register selection
  function automatic blt_sel_t decode(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    decode = SEL_NONE;
    if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0)
      decode = SEL_NONE;
    else if (idx == `BLT_IDX_OVR_EN)
      decode = SEL_OVR_EN;
    else if (idx == `BLT_IDX_LINK_RDY)
      decode = SEL_LINK_RDY;
    else if (idx == `BLT_IDX_ABILITY)
      decode = SEL_ABILITY;
    else if (idx == `BLT_IDX_MASTER)
      decode = SEL_MASTER;
    else if (idx == `BLT_IDX_COEF_CTL)
      decode = SEL_COEF_CTL;
    else if (idx == `BLT_IDX_STROBES)
      decode = SEL_STROBES;
    else if (idx >= `BLT_IDX_COEF_FIRST && idx <= `BLT_IDX_COEF_LAST)
      decode = SEL_COEF;
  endfunction : decode

  // ****************************************************************
  // Write channel
  // ****************************************************************
  // Address and data are taken in either order; the write happens once both are held
  assign awready = !awHeld_q && !bvalid_q;
  assign wready = !wHeld_q && !bvalid_q;
  assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
  assign wrSel = decode(awAddr_q);
  assign wrMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

  // Capture address and data
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      else if (doWrite)
        awHeld_q <= 1'b0;
      if (wvalid && wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      else if (doWrite)
        wHeld_q <= 1'b0;
    end
  end

  // Write response, error for unmapped addresses
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `BLT_RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wrSel == SEL_NONE) ? `BLT_RESP_SLVERR : `BLT_RESP_OKAY;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Override enables; writes honour byte strobes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      overrideEn_q <= 1'b0;
      partnerOvr_q <= 1'b0;
      localOvr_q <= 1'b0;
      masterSel_q <= `BLT_MASTER_RST;
    end
    else if (doWrite)
    begin
      if (wrSel == SEL_OVR_EN && wrMask[`BLT_OVR_EN_BIT])
        overrideEn_q <= wData_q[`BLT_OVR_EN_BIT];
      if (wrSel == SEL_MASTER && wrMask[0])
        masterSel_q <= wData_q[3:0];
      if (wrSel == SEL_COEF_CTL && wrMask[`BLT_PART_OVR_BIT])
      begin
        partnerOvr_q <= wData_q[`BLT_PART_OVR_BIT];
        localOvr_q <= wData_q[`BLT_LOCAL_OVR_BIT];
      end
    end
  end

  // master lane choice
  // A pattern that is not one-hot keeps the build-time lane rather than naming no lane
  assign selOneHot = (masterSel_q != 4'h0) && ((masterSel_q & (masterSel_q - 4'h1)) == 4'h0);
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      masterLane_q <= DEFAULT_MASTER_LANE;
    else
      masterLane_q <= (overrideEn_q && selOneHot) ? masterSel_q : DEFAULT_MASTER_LANE;
  end
  assign masterLane = masterLane_q;

  // ****************************************************************
  // Status registers
  // ****************************************************************
  // link-ready status tracks receive-idle and link up
  // only the 40G four-lane code is ever reported
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      linkReady_q <= `BLT_LINK_RDY_RST;
    else
      linkReady_q <= (anReceiveIdle && anLinkUp) ? `BLT_LINK_RDY_KR4 : `BLT_LINK_RDY_NONE;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ability_q <= `BLT_ABILITY_RST;
    else if (abilityValid)
      ability_q <= partnerAbility;
  end
  // only the 40G four-lane ability bit qualifies
  assign partnerKr4Ok = ability_q[`BLT_KR4_ABILITY_BIT];

  // ****************************************************************
  // Strobes and lanes
  // ****************************************************************
  // strobes pulse once per write
  blt_sc_strobe #(.WIDTH(12)) uStrobe (
    .clock(clock),
    .rst(rst),
    .wrEn(doWrite && wrSel == SEL_STROBES),
    .setBits(wData_q[11:0] & wrMask[11:0]),
    .pulse(strobes)
  );
  assign restartTraining = strobes[`BLT_RESTART_LSB +: 4];

  genvar ln;
  generate
    for (ln = 0; ln < 4; ln++)
    begin : gLane
      blt_lane_coef uLane (
        .clock(clock),
        .rst(rst),
        .wrEn(doWrite && wrSel == SEL_COEF && awAddr_q[3:2] == 2'(ln)),
        .wrData(wData_q),
        .wrMask(wrMask),
        .partnerOvr(partnerOvr_q),
        .localOvr(localOvr_q),
        .partnerStrobe(strobes[`BLT_PART_NEW_LSB + ln]),
        .localStrobe(strobes[`BLT_LOCAL_NEW_LSB + ln]),
        .trainPartnerCoef(trainPartnerCoef[8*ln +: 8]),
        .derivedLocalCoef(derivedLocalCoef[8*ln +: 8]),
        .swPartner(swPartnerAll[8*ln +: 8]),
        .swLocal(swLocalAll[8*ln +: 8]),
        .partnerLoad(partnerCoefLoad[ln]),
        .localLoad(localCoefLoad[ln]),
        .partnerCoef(partnerCoef[8*ln +: 8]),
        .localCoef(localCoef[8*ln +: 8])
      );
    end
  endgenerate

  // ****************************************************************
  // Read channel
  // ****************************************************************
  assign arready = !rvalid_q;
  assign rdSel = decode(araddr);

  // Read data registered on the address handshake
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `BLT_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= (rdSel == SEL_NONE) ? `BLT_RESP_SLVERR : `BLT_RESP_OKAY;
      rdata_q <= 32'h00000000;
      unique case (rdSel)
        SEL_OVR_EN: rdata_q[`BLT_OVR_EN_BIT] <= overrideEn_q;
        SEL_LINK_RDY: rdata_q[`BLT_LINK_RDY_LSB +: 6] <= linkReady_q;
        SEL_ABILITY: rdata_q[24:0] <= ability_q;
        SEL_MASTER: rdata_q[3:0] <= masterSel_q;
        SEL_COEF_CTL: rdata_q[`BLT_LOCAL_OVR_BIT:`BLT_PART_OVR_BIT] <= {localOvr_q, partnerOvr_q};
        SEL_STROBES: rdata_q[11:0] <= strobes;
        SEL_COEF:
        begin
          rdata_q[`BLT_PART_COEF_LSB +: 8] <= swPartnerAll[8*araddr[3:2] +: 8];
          rdata_q[`BLT_LOCAL_COEF_LSB +: 8] <= swLocalAll[8*araddr[3:2] +: 8];
        end
        SEL_NONE: rdata_q <= 32'h00000000;
      endcase
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_link_ready;
    @(posedge clock) disable iff (rst)
    (anReceiveIdle && anLinkUp) |=> linkReady_q == 6'h08;
  endproperty
  a_link_ready: assert property (p_link_ready) else $error("link ready code wrong");

  property p_link_down;
    @(posedge clock) disable iff (rst)
    !(anReceiveIdle && anLinkUp) |=> linkReady_q == 6'h00;
  endproperty
  a_link_down: assert property (p_link_down) else $error("link ready not cleared");

  property p_ability;
    @(posedge clock) disable iff (rst)
    abilityValid |=> ability_q == $past(partnerAbility);
  endproperty
  a_ability: assert property (p_ability) else $error("ability not captured");

  property p_kr4;
    @(posedge clock) disable iff (rst)
    (abilityValid && partnerAbility[3]) |=> partnerKr4Ok;
  endproperty
  a_kr4: assert property (p_kr4) else $error("ability bit not reported");

  property p_master_ovr;
    @(posedge clock) disable iff (rst)
    (overrideEn_q && masterSel_q == 4'h4) |=> masterLane == 4'h4;
  endproperty
  a_master_ovr: assert property (p_master_ovr) else $error("override lane ignored");

  property p_master_dflt;
    @(posedge clock) disable iff (rst)
    (!overrideEn_q || !selOneHot) |=> masterLane == DEFAULT_MASTER_LANE;
  endproperty
  a_master_dflt: assert property (p_master_dflt) else $error("default lane lost");

  sequence s_restart_write;
    doWrite && wrSel == SEL_STROBES && wData_q[0] && wrMask[0];
  endsequence
  property p_restart;
    @(posedge clock) disable iff (rst)
    s_restart_write |=> restartTraining[0] ##1 !restartTraining[0];
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse wrong");

  property p_single;
    @(posedge clock) disable iff (rst)
    strobes[5] |=> !strobes[5];
  endproperty
  a_single: assert property (p_single) else $error("strobe held too long");

  property p_partner_gate;
    @(posedge clock) disable iff (rst)
    partnerCoefLoad[1] |-> partnerOvr_q && strobes[5];
  endproperty
  a_partner_gate: assert property (p_partner_gate) else $error("partner load ungated");

  property p_local_gate;
    @(posedge clock) disable iff (rst)
    (strobes[9] && !localOvr_q) |-> !localCoefLoad[1];
  endproperty
  a_local_gate: assert property (p_local_gate) else $error("local load ungated");

  property p_partner_train;
    @(posedge clock) disable iff (rst)
    !partnerOvr_q |=> partnerCoef[7:0] == $past(trainPartnerCoef[7:0]);
  endproperty
  a_partner_train: assert property (p_partner_train) else $error("partner path wrong");

  property p_write_resp;
    @(posedge clock) disable iff (rst)
    doWrite |=> bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("no write response");
endmodule : blt_regs

// ---- bench/blt_far_end.sv ----
/*
  Far-side model for the training register bank: negotiation status, received
  ability word and per-cycle coefficient streams. Assumes the bench steers it.
*/
`timescale 1ns/10ps
module blt_far_end
  import blt_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic idleIn,
  input wire logic upIn,
  input wire logic sendAbility,
  input wire logic [24:0] abilityWord,
  output logic anReceiveIdle,
  output logic anLinkUp,
  output logic abilityValid,
  output logic [24:0] partnerAbility,
  output logic [31:0] trainPartnerCoef,
  output logic [31:0] derivedLocalCoef
);
  blt_coef_t step_q;
  // Streams move every cycle so a stale sample never passes for a fresh one
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      step_q <= 8'h00;
    else
      step_q <= step_q + 8'h13;
  end
  assign trainPartnerCoef = {4{step_q}};
  assign derivedLocalCoef = ~{4{step_q}};
  // Status levels and ability word; the word is inverted while not valid
  assign anReceiveIdle = idleIn;
  assign anLinkUp = upIn;
  assign abilityValid = sendAbility;
  assign partnerAbility = sendAbility ? abilityWord : ~abilityWord;
endmodule : blt_far_end

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the training register bank over AXI4-Lite.
  Assumes the far-side model and the register bank are compiled before it.
*/
`timescale 1ns/10ps
`include "blt_params.svh"
module tb_top
  import blt_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam blt_lane_mask_t DEF = 4'h2;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] r;
    blt_resp_t e;} blt_row_t;
  logic clock, rst, awvalid, wvalid, bready, arvalid, rready, idleIn, upIn, sendAb;
  logic awready, wready, bvalid, arready, rvalid, partnerKr4Ok, awHit, wHit, arHit;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, partnerCoef, localCoef, trainP, derivL, prevP, prevL;
  logic [3:0] wstrb;
  logic [24:0] abWord, partnerAbility;
  logic anReceiveIdle, anLinkUp, abilityValid;
  blt_resp_t bresp, rresp;
  blt_lane_mask_t masterLane, restartTraining, partnerCoefLoad, localCoefLoad;
  logic [11:0] pulseA, pulseB;
  int err_count, compares;
  blt_row_t rows[8];
  blt_regs #(.DEFAULT_MASTER_LANE(DEF)) dut (.clock(clock), .rst(rst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .anReceiveIdle(anReceiveIdle), .anLinkUp(anLinkUp),
    .abilityValid(abilityValid), .partnerAbility(partnerAbility),
    .partnerKr4Ok(partnerKr4Ok), .masterLane(masterLane), .restartTraining(restartTraining),
    .partnerCoefLoad(partnerCoefLoad), .localCoefLoad(localCoefLoad),
    .trainPartnerCoef(trainP), .derivedLocalCoef(derivL), .partnerCoef(partnerCoef),
    .localCoef(localCoef));
  blt_far_end far (.clock(clock), .rst(rst), .idleIn(idleIn), .upIn(upIn),
    .sendAbility(sendAb), .abilityWord(abWord), .anReceiveIdle(anReceiveIdle),
    .anLinkUp(anLinkUp), .abilityValid(abilityValid), .partnerAbility(partnerAbility),
    .trainPartnerCoef(trainP), .derivedLocalCoef(derivL));
  // Clock at 25 MHz
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Handshakes seen at the edge, and coefficient inputs one clock back
  always @(posedge clock)
  begin
    awHit <= awvalid && awready;
    wHit <= wvalid && wready;
    arHit <= arvalid && arready;
    prevP <= trainP;
    prevL <= derivL;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Write; pulses are caught in the response cycle and the one after
  task automatic axWr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    input blt_resp_t e);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(posedge clock); #1;
      if (awHit) awvalid <= 1'b0;
      if (wHit) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    pulseA = {localCoefLoad, partnerCoefLoad, restartTraining};
    chk("bresp", 32'(e), 32'(bresp));
    @(posedge clock); #1;
    bready <= 1'b0;
    pulseB = {localCoefLoad, partnerCoefLoad, restartTraining};
  endtask : axWr
  task automatic axRd(input logic [11:0] a, input logic [31:0] x, input blt_resp_t e);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(posedge clock); #1;
      if (arHit) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk("rdata", x, rdata);
    chk("rresp", 32'(e), 32'(rresp));
    @(posedge clock); #1;
    rready <= 1'b0;
  endtask : axRd
  task automatic doReset();
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    #1 rst <= 1'b0;
  endtask : doReset
  task automatic wrap_up();
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // Watchdog well beyond the expected hundred or so cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    err_count++;
    wrap_up();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst <= 1'b1; awvalid <= '0; wvalid <= '0; bready <= '0; arvalid <= '0; rready <= '0;
    awaddr <= '0; araddr <= '0; wdata <= '0; wstrb <= '0; idleIn <= '0; upIn <= '0;
    sendAb <= '0; abWord <= '0;
    rows = '{'{12'h300, 32'h40, 4'hF, 32'h40, `BLT_RESP_OKAY},
      '{12'h330, 32'h4, 4'hF, 32'h4, `BLT_RESP_OKAY},
      '{12'h340, 32'h30000, 4'hF, 32'h30000, `BLT_RESP_OKAY},
      '{12'h340, 32'h0, 4'h3, 32'h30000, `BLT_RESP_OKAY},
      '{12'h350, 32'h00CD00AB, 4'hF, 32'h00CD00AB, `BLT_RESP_OKAY},
      '{12'h35C, 32'h00EF0012, 4'hF, 32'h00EF0012, `BLT_RESP_OKAY},
      '{12'h3F0, 32'hFFFF, 4'hF, 32'h0, `BLT_RESP_SLVERR},
      '{12'h302, 32'hFFFF, 4'hF, 32'h0, `BLT_RESP_SLVERR}};
    doReset();
    // Table cases, unmapped and misaligned addresses included: write then read back each row
    foreach (rows[i])
    begin
      axWr(rows[i].a, rows[i].d, rows[i].s, rows[i].e);
      axRd(rows[i].a, rows[i].r, rows[i].e);
    end
    chk("masterLane", 32'h4, 32'(masterLane));
    // Second reset in mid-run restores reset values
    doReset();
    chk("masterLane", 32'(DEF), 32'(masterLane));
    axRd(12'h330, 32'h0, `BLT_RESP_OKAY);
    axRd(12'h32C, 32'h0, `BLT_RESP_OKAY);
    axRd(12'h340, 32'h0, `BLT_RESP_OKAY);
    // Link ready needs idle and link up together
    upIn <= 1'b1;
    axRd(12'h308, 32'h0, `BLT_RESP_OKAY);
    idleIn <= 1'b1;
    // Status register takes one clock to follow the levels
    @(posedge clock);
    axRd(12'h308, 32'h8000, `BLT_RESP_OKAY);
    // Ability capture; only bit 3 counts as valid
    abWord <= 25'h0000008; sendAb <= 1'b1;
    @(posedge clock); #1 sendAb <= 1'b0;
    axRd(12'h32C, 32'h8, `BLT_RESP_OKAY);
    chk("partnerKr4Ok", 32'h1, 32'(partnerKr4Ok));
    abWord <= 25'h1FFFFF7; sendAb <= 1'b1;
    @(posedge clock); #1 sendAb <= 1'b0;
    axRd(12'h32C, 32'h1FFFFF7, `BLT_RESP_OKAY);
    chk("partnerKr4Ok", 32'h0, 32'(partnerKr4Ok));
    // Override to lane 3, then an invalid select, then override off
    axWr(12'h330, 32'h8, 4'hF, `BLT_RESP_OKAY);
    axWr(12'h300, 32'h40, 4'hF, `BLT_RESP_OKAY);
    chk("masterLane", 32'h8, 32'(masterLane));
    axWr(12'h330, 32'h3, 4'hF, `BLT_RESP_OKAY);
    chk("masterLane", 32'(DEF), 32'(masterLane));
    // A valid lane other than the default, so that clearing the enable shows
    axWr(12'h330, 32'h1, 4'hF, `BLT_RESP_OKAY);
    chk("masterLane", 32'h1, 32'(masterLane));
    axWr(12'h300, 32'h0, 4'hF, `BLT_RESP_OKAY);
    chk("masterLane", 32'(DEF), 32'(masterLane));
    // Restart all lanes: one-cycle pulse only
    axWr(12'h344, 32'hF, 4'hF, `BLT_RESP_OKAY);
    chk("restart", 32'hF, 32'(pulseA));
    chk("restartAfter", 32'h0, 32'(pulseB));
    // Strobes without override do nothing; coefficients follow training
    axWr(12'h354, 32'h00A5005A, 4'hF, `BLT_RESP_OKAY);
    axWr(12'h344, 32'h220, 4'hF, `BLT_RESP_OKAY);
    chk("loadsOff", 32'h0, 32'(pulseA));
    chk("partnerCoef", prevP, partnerCoef);
    chk("localCoef", prevL, localCoef);
    // With both overrides the strobes load software values for lane 1
    axWr(12'h340, 32'h30000, 4'hF, `BLT_RESP_OKAY);
    axWr(12'h344, 32'h220, 4'hF, `BLT_RESP_OKAY);
    chk("loadsOn", 32'h220, 32'(pulseA));
    chk("loadsAfter", 32'h0, 32'(pulseB));
    chk("partnerLane1", 32'h5A, 32'(partnerCoef[15:8]));
    chk("localLane1", 32'hA5, 32'(localCoef[15:8]));
    axRd(12'h344, 32'h0, `BLT_RESP_OKAY);
    wrap_up();
  end
endmodule : tb_top
